// ### shared/cth_pkg.sv
// shared constants and carrier types for the touch and hall channel ui
package cth_pkg;
  // register offsets
  localparam logic [7:0] ADDR_FLAGS    = 8'h11;
  localparam logic [7:0] ADDR_SET_A0   = 8'h40;
  localparam logic [7:0] ADDR_SET_A1   = 8'h41;
  localparam logic [7:0] ADDR_SET_B    = 8'h42;
  localparam logic [7:0] ADDR_TUNE0    = 8'h43;
  localparam logic [7:0] ADDR_TUNE1    = 8'h44;
  localparam logic [7:0] ADDR_SET_D    = 8'h45;
  localparam logic [7:0] ADDR_NEAR0    = 8'h50;
  localparam logic [7:0] ADDR_CONTACT0 = 8'h51;
  localparam logic [7:0] ADDR_NEAR1    = 8'h52;
  localparam logic [7:0] ADDR_CONTACT1 = 8'h53;
  // flag and control bit positions
  localparam int FLG_NEAR0     = 0;
  localparam int FLG_NEAR1     = 1;
  localparam int FLG_CONTACT0  = 4;
  localparam int FLG_CONTACT1  = 5;
  localparam int SET_B_GO_BIT  = 0;
  localparam int SET_B_BUSY_BIT = 1;
  // tuning byte fields: target code high nibble, base code low nibble
  localparam int TGT_MSB       = 7;
  localparam int TGT_LSB       = 4;
  localparam int BASE_CRS_MSB  = 3;
  localparam int BASE_CRS_LSB  = 2;
  localparam int BASE_FIN_MSB  = 1;
  localparam int BASE_FIN_LSB  = 0;
  // threshold floor for writes, then reset values
  localparam logic [7:0] THR_MIN       = 8'h01;
  localparam logic [7:0] NEAR_THR_RST  = 8'h10;
  localparam logic [7:0] CONTACT_X_RST = 8'h20;
  localparam logic [7:0] SET_RST       = 8'h00;
  localparam logic [7:0] TUNING_RST    = 8'h88;
  // channel allocation
  localparam logic [2:0] CH_CAP_ZERO   = 3'h0;
  localparam logic [2:0] CH_CAP_ONE    = 3'h1;
  localparam logic [2:0] CH_HALL_FIRST = 3'h2;
  localparam logic [2:0] CH_PLATE_B_N  = 3'h5;
  // tuning and averaging
  localparam int         COMP_W          = 10;
  localparam logic [3:0] TUNE_MSB        = 4'h9;
  localparam logic [9:0] TUNE_COMP_START = 10'h200;
  localparam int         LTA_SHIFT       = 4;

  typedef struct packed {
    logic        vld;
    logic [2:0]  chan;
    logic [15:0] count;
  } cth_conv_s;

  typedef struct packed {
    logic [1:0]        coarse;
    logic [1:0]        fine;
    logic [COMP_W-1:0] comp;
  } cth_tune_s;

  typedef struct packed {
    logic               vld;
    logic signed [16:0] plate_a;
    logic signed [16:0] plate_b;
  } cth_hall_s;

  typedef struct packed {
    logic [7:0] set_a0;
    logic [7:0] set_a1;
    logic [7:0] set_b;
    logic [7:0] set_d;
  } cth_cfg_s;
endpackage

// ### rtl/cth_chan_eval.sv
// one capacitive channel: long-term average, near/contact flags, auto-tuning
`timescale 1ns/1ps
module cth_chan_eval #(
  parameter logic [2:0] CHAN_ID = 3'h0
) (
  input  wire logic              core_clk,     // core clock
  input  wire logic              nrst,         // async reset, low
  input  wire cth_pkg::cth_conv_s conv,        // finished conversion
  input  wire logic [7:0]        near_thr,     // near threshold, counts
  input  wire logic [7:0]        contact_x,    // contact numerator
  input  wire logic [7:0]        tuning,       // target and base codes
  input  wire logic              tune_go,      // start tuning, pulse
  output      logic              near_flag,    // delta above near threshold
  output      logic              contact_flag, // delta above contact threshold
  output      cth_pkg::cth_tune_s tune_val,    // multipliers and compensation
  output      logic              tune_busy     // tuning in progress
);
  import cth_pkg::*;

  typedef struct packed {
    logic [15:0] long_term_average;
    logic        seeded;
    logic        near;
    logic        contact;
    logic        busy;
    logic [3:0]  bit_idx;
    cth_tune_s   tune;
  } cth_eval_s;

  cth_eval_s          st_ff;
  cth_eval_s          nxt_st;
  logic               hit;
  logic [15:0]        delta;
  logic [23:0]        prod;
  logic [15:0]        contact_thr;
  logic [15:0]        target;
  logic [16:0]        diff;
  logic signed [16:0] step;
  logic [16:0]        lta_sum;

  // delta, contact threshold and average step
  always_comb
  begin
    hit         = conv.vld && (conv.chan == CHAN_ID);
    delta       = (conv.count > st_ff.long_term_average) ? 16'(conv.count - st_ff.long_term_average) : 16'h0000;
    prod        = contact_x * st_ff.long_term_average;
    contact_thr = prod[23:8];
    target      = {4'h0, tuning[TGT_MSB:TGT_LSB], 8'h00};
    diff        = {1'b0, conv.count} - {1'b0, st_ff.long_term_average};
    step        = $signed(diff) >>> LTA_SHIFT;
    lta_sum     = {1'b0, st_ff.long_term_average} + step;
  end

  // next state: tuning start, tuning step, flag evaluation
  always_comb
  begin
    nxt_st = st_ff;
    if (tune_go)
    begin
      nxt_st.busy        = 1'b1;
      nxt_st.bit_idx     = TUNE_MSB;
      nxt_st.tune.comp   = TUNE_COMP_START;
      nxt_st.tune.coarse = tuning[BASE_CRS_MSB:BASE_CRS_LSB];
      nxt_st.tune.fine   = tuning[BASE_FIN_MSB:BASE_FIN_LSB];
      nxt_st.near        = 1'b0;
      nxt_st.contact     = 1'b0;
      nxt_st.seeded      = 1'b0;
    end
    else if (hit && st_ff.busy)
    begin
      // successive approximation, one compensation bit per conversion
      if (conv.count > target)
        nxt_st.tune.comp[st_ff.bit_idx] = 1'b0;
      if (st_ff.bit_idx == 4'h0)
        nxt_st.busy = 1'b0;
      else
      begin
        nxt_st.bit_idx = 4'(st_ff.bit_idx - 4'h1);
        nxt_st.tune.comp[4'(st_ff.bit_idx - 4'h1)] = 1'b1;
      end
    end
    else if (hit && !st_ff.seeded)
    begin
      nxt_st.long_term_average     = conv.count; // first sample seeds the average
      nxt_st.seeded  = 1'b1;
      nxt_st.near    = 1'b0;
      nxt_st.contact = 1'b0;
    end
    else if (hit)
    begin
      nxt_st.near    = delta > {8'h00, near_thr};
      nxt_st.contact = delta > contact_thr;
      nxt_st.long_term_average     = lta_sum[15:0];
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign near_flag    = st_ff.near;
  assign contact_flag = st_ff.contact;
  assign tune_val     = st_ff.tune;
  assign tune_busy    = st_ff.busy;

  // near flag follows delta against threshold after each conversion once seeded and not tuning
  property p_near_eval;
    @(posedge core_clk) disable iff (!nrst)
    (hit && !tune_go && !st_ff.busy && st_ff.seeded)
      |=> (near_flag == ($past(delta) > {8'h00, $past(near_thr)}));
  endproperty
  a_near_eval: assert property (p_near_eval) else $error("near flag wrong");

  // contact flag follows delta against the scaled average
  property p_contact_eval;
    @(posedge core_clk) disable iff (!nrst)
    (hit && !tune_go && !st_ff.busy && st_ff.seeded)
      |=> (contact_flag == ($past(delta) > $past(contact_thr)));
  endproperty
  a_contact_eval: assert property (p_contact_eval) else $error("contact flag wrong");

  // tuning starts at mid-scale with base-derived multipliers
  property p_tune_start;
    @(posedge core_clk) disable iff (!nrst)
    tune_go |=> tune_busy && (tune_val.comp == TUNE_COMP_START)
      && (tune_val.coarse == $past(tuning[BASE_CRS_MSB:BASE_CRS_LSB]));
  endproperty
  a_tune_start: assert property (p_tune_start) else $error("tuning start wrong");

  // tuning ends only on the conversion that settles bit 0
  property p_tune_end;
    @(posedge core_clk) disable iff (!nrst)
    $fell(tune_busy) |-> $past(hit) && ($past(st_ff.bit_idx) == 4'h0);
  endproperty
  a_tune_end: assert property (p_tune_end) else $error("tuning ended early");
endmodule

// ### rtl/cth_ui_top.sv
// register file, flag reporting and hall differencing for the sensor ui
`timescale 1ns/1ps
// Function
// - tuning sets multipliers, compensation from base, target
// - compensation value is ten bits wide
// - only channels zero and one sense capacitance
// - each capacitive channel has own settings
// - near threshold ranges one to 255
// - near flags bits 0,1 follow delta
// - contact threshold is x/256 times average
// - contact flags bits 4,5 follow delta
// - flags readable in one read-only register
// - channels two to five are hall only
// - channels 2,4 positive; 3,5 negative
// - channels 2,3 plate one; 4,5 plate two
// - hall differences feed the angle calculation
module cth_ui_top (
  input  wire logic               core_clk,   // core clock, 100 MHz
  input  wire logic               nrst,       // async reset, low
  input  wire cth_pkg::cth_conv_s conv_in,    // finished conversion, any channel
  input  wire logic [7:0]         reg_addr,   // register offset
  input  wire logic               reg_wr,     // write strobe
  input  wire logic               reg_rd,     // read strobe
  input  wire logic [7:0]         reg_wdata,  // write data
  output      logic [7:0]         reg_rdata,  // read data, registered
  output      logic               reg_rvld,   // read data valid, pulse
  output      cth_pkg::cth_cfg_s  sense_cfg,  // stored sensor settings
  output      cth_pkg::cth_tune_s tune_zero,  // tuning result channel zero
  output      cth_pkg::cth_tune_s tune_one,   // tuning result channel one
  output      cth_pkg::cth_hall_s hall_out    // plate differences for angle
);
  import cth_pkg::*;

  typedef struct packed {
    logic [1:0][7:0]  near_thr;
    logic [1:0][7:0]  contact_x;
    logic [1:0][7:0]  set_a;
    logic [1:0][7:0]  tuning;
    logic [7:0]       set_b;
    logic [7:0]       set_d;
    logic [3:0][15:0] hall_cnt;
    cth_hall_s        hall;
    logic [7:0]       rdata;
    logic             rvld;
    logic             tune_go;
  } cth_top_s;

  cth_top_s   st_ff;
  cth_top_s   nxt_st;
  logic [1:0] near_q;
  logic [1:0] contact_q;
  logic [1:0] busy_q;
  cth_tune_s  tune_q [0:1];
  logic [7:0] flags;
  logic [7:0] rd_mux;
  logic       hall_hit;
  logic [2:0] hall_idx;
  logic [7:0] wr_thr;

  // one evaluator per capacitive channel, each with its own settings
  generate
    for (genvar gi = 0; gi < 2; gi++)
    begin : g_cap
      cth_chan_eval #(
        .CHAN_ID (3'(gi))
      ) i_cth_chan_eval (
        .core_clk     (core_clk),
        .nrst         (nrst),
        .conv         (conv_in),
        .near_thr     (st_ff.near_thr[gi]),
        .contact_x    (st_ff.contact_x[gi]),
        .tuning       (st_ff.tuning[gi]),
        .tune_go      (st_ff.tune_go),
        .near_flag    (near_q[gi]),
        .contact_flag (contact_q[gi]),
        .tune_val     (tune_q[gi]),
        .tune_busy    (busy_q[gi])
      );
    end
  endgenerate

  // flags register image, unused bits tied low
  always_comb
  begin
    flags               = 8'h00;
    flags[FLG_NEAR0]    = near_q[0];
    flags[FLG_NEAR1]    = near_q[1];
    flags[FLG_CONTACT0] = contact_q[0];
    flags[FLG_CONTACT1] = contact_q[1];
  end

  // read multiplexer, unmapped offsets read zero
  always_comb
  begin
    rd_mux = 8'h00;
    case (reg_addr)
      ADDR_FLAGS:    rd_mux = flags;
      ADDR_SET_A0:   rd_mux = st_ff.set_a[0];
      ADDR_SET_A1:   rd_mux = st_ff.set_a[1];
      ADDR_SET_B:
      begin
        rd_mux                 = st_ff.set_b;
        rd_mux[SET_B_GO_BIT]   = 1'b0;
        rd_mux[SET_B_BUSY_BIT] = |busy_q;
      end
      ADDR_TUNE0:    rd_mux = st_ff.tuning[0];
      ADDR_TUNE1:    rd_mux = st_ff.tuning[1];
      ADDR_SET_D:    rd_mux = st_ff.set_d;
      ADDR_NEAR0:    rd_mux = st_ff.near_thr[0];
      ADDR_CONTACT0: rd_mux = st_ff.contact_x[0];
      ADDR_NEAR1:    rd_mux = st_ff.near_thr[1];
      ADDR_CONTACT1: rd_mux = st_ff.contact_x[1];
      default:       rd_mux = 8'h00;
    endcase
  end

  // next state: register writes, read capture, hall differencing
  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.rvld    = reg_rd;
    nxt_st.tune_go = 1'b0;
    nxt_st.hall.vld = 1'b0;
    wr_thr   = (reg_wdata == 8'h00) ? THR_MIN : reg_wdata;
    hall_idx = 3'(conv_in.chan - CH_HALL_FIRST);
    hall_hit = conv_in.vld && (conv_in.chan >= CH_HALL_FIRST)
               && (conv_in.chan <= CH_PLATE_B_N);
    if (reg_rd)
      nxt_st.rdata = rd_mux;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_SET_A0:   nxt_st.set_a[0] = reg_wdata;
        ADDR_SET_A1:   nxt_st.set_a[1] = reg_wdata;
        ADDR_SET_B:
        begin
          nxt_st.set_b                 = reg_wdata;
          nxt_st.set_b[SET_B_GO_BIT]   = 1'b0;
          nxt_st.set_b[SET_B_BUSY_BIT] = 1'b0;
          nxt_st.tune_go               = reg_wdata[SET_B_GO_BIT];
        end
        ADDR_TUNE0:    nxt_st.tuning[0]    = reg_wdata;
        ADDR_TUNE1:    nxt_st.tuning[1]    = reg_wdata;
        ADDR_SET_D:    nxt_st.set_d        = reg_wdata;
        ADDR_NEAR0:    nxt_st.near_thr[0]  = wr_thr;
        ADDR_CONTACT0: nxt_st.contact_x[0] = wr_thr;
        ADDR_NEAR1:    nxt_st.near_thr[1]  = wr_thr;
        ADDR_CONTACT1: nxt_st.contact_x[1] = wr_thr;
        default:       nxt_st.rdata        = nxt_st.rdata; // read-only or unmapped
      endcase
    end
    if (hall_hit)
    begin
      nxt_st.hall_cnt[hall_idx[1:0]] = conv_in.count;
      if (conv_in.chan == CH_PLATE_B_N)
      begin
        // plate one: ch2 minus ch3; plate two: ch4 minus ch5
        nxt_st.hall.plate_a = $signed({1'b0, st_ff.hall_cnt[0]})
                              - $signed({1'b0, st_ff.hall_cnt[1]});
        nxt_st.hall.plate_b = $signed({1'b0, st_ff.hall_cnt[2]})
                              - $signed({1'b0, conv_in.count});
        nxt_st.hall.vld     = 1'b1;
      end
    end
  end

  // state register with settings reset values
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff           <= '0;
      st_ff.near_thr  <= {NEAR_THR_RST, NEAR_THR_RST};
      st_ff.contact_x <= {CONTACT_X_RST, CONTACT_X_RST};
      st_ff.set_a     <= {SET_RST, SET_RST};
      st_ff.tuning    <= {TUNING_RST, TUNING_RST};
      st_ff.set_b     <= SET_RST;
      st_ff.set_d     <= SET_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // outputs straight from flip-flops
  assign reg_rdata        = st_ff.rdata;
  assign reg_rvld         = st_ff.rvld;
  assign sense_cfg.set_a0 = st_ff.set_a[0];
  assign sense_cfg.set_a1 = st_ff.set_a[1];
  assign sense_cfg.set_b  = st_ff.set_b;
  assign sense_cfg.set_d  = st_ff.set_d;
  assign tune_zero        = tune_q[0];
  assign tune_one         = tune_q[1];
  assign hall_out         = st_ff.hall;

  // a zero threshold write lands as one
  property p_near_clamp;
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && (reg_addr == ADDR_NEAR0) && (reg_wdata == 8'h00))
      |=> (st_ff.near_thr[0] == THR_MIN);
  endproperty
  a_near_clamp: assert property (p_near_clamp) else $error("near threshold not clamped");

  // flags read shows live flags with idle bits zero
  property p_flags_read;
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && (reg_addr == ADDR_FLAGS))
      |=> reg_rvld && (reg_rdata[7:6] == 2'b00) && (reg_rdata[3:2] == 2'b00)
          && (reg_rdata[FLG_CONTACT1] == $past(contact_q[1]))
          && (reg_rdata[FLG_NEAR0] == $past(near_q[0]));
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flags read wrong");

  // writing the flags offset changes nothing stored
  property p_flags_ro;
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && (reg_addr == ADDR_FLAGS)) |=> $stable(st_ff.near_thr) && $stable(st_ff.set_b);
  endproperty
  a_flags_ro: assert property (p_flags_ro) else $error("flags offset took a write");

  // settings of one channel untouched by writes to the other
  property p_chan_apart;
    @(posedge core_clk) disable iff (!nrst)
    (reg_wr && (reg_addr == ADDR_CONTACT0))
      |=> $stable(st_ff.contact_x[1]) && (st_ff.contact_x[0] != 8'h00);
  endproperty
  a_chan_apart: assert property (p_chan_apart) else $error("channel settings crossed");

  // hall conversions never move capacitive flags
  property p_hall_only;
    @(posedge core_clk) disable iff (!nrst)
    (conv_in.vld && (conv_in.chan >= CH_HALL_FIRST) && !st_ff.tune_go)
      |=> $stable(near_q) && $stable(contact_q);
  endproperty
  a_hall_only: assert property (p_hall_only) else $error("hall sample hit a cap flag");

  // last hall channel yields both plate differences one cycle later
  property p_hall_diff;
    @(posedge core_clk) disable iff (!nrst)
    (conv_in.vld && (conv_in.chan == CH_PLATE_B_N))
      |=> hall_out.vld
          && (hall_out.plate_b == ($signed({1'b0, $past(st_ff.hall_cnt[2])})
                                   - $signed({1'b0, $past(conv_in.count)})))
          ##1 !hall_out.vld || $past(conv_in.vld);
  endproperty
  a_hall_diff: assert property (p_hall_diff) else $error("hall difference wrong");

  // unmapped reads below the settings block answer zero
  property p_unmapped;
    @(posedge core_clk) disable iff (!nrst)
    (reg_rd && ((reg_addr < ADDR_FLAGS)
                || ((reg_addr > ADDR_FLAGS) && (reg_addr < ADDR_SET_A0))))
      |=> reg_rvld && (reg_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// ### dv/cth_host_model.sv
// host-side register master that talks to the sensor ui registers
`timescale 1ns/1ps
module cth_host_model (
  input  wire logic       core_clk,  // core clock
  input  wire logic [7:0] reg_rdata, // read data from the ui
  input  wire logic       reg_rvld,  // read data valid pulse
  output      logic [7:0] reg_addr,  // register offset
  output      logic       reg_wr,    // write strobe
  output      logic       reg_rd,    // read strobe
  output      logic [7:0] reg_wdata  // write data
);
  // bus idle at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one-cycle write; address, data and strobe set up on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge core_clk);
    reg_wr    = 1'b0;
  endtask

  // one-cycle read; answer taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge core_clk);
    reg_rd   = 1'b0;
    v        = reg_rvld;
    d        = reg_rdata;
  endtask
endmodule

// ### dv/tb_cth_ui_top.sv
// self-checking bench for the sensor ui with an integer reference model
`timescale 1ns/1ps
module tb_cth_ui_top;
  import cth_pkg::*;
  logic              core_clk  = 1'b0;
  logic              nrst      = 1'b0;
  cth_conv_s         conv_in   = '0;
  logic [7:0]        reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata;
  logic              reg_rvld;
  cth_cfg_s          sense_cfg;
  cth_tune_s         tune_zero;
  cth_tune_s         tune_one;
  cth_hall_s         hall_out;
  logic [31:0]       rs        = 32'h7e4c;
  int                err_total = 0;
  int                n_compared = 0;
  logic [7:0]        mreg [256];
  int                long_term_average  [2];
  int                sdd  [2];
  int                tix  [2];
  logic [9:0]        tcmp [2];
  int                hc   [8];
  logic [7:0]        fl        = 8'h00;
  logic [7:0]        addrs [12] = '{8'h11, 8'h30, 8'h40, 8'h41, 8'h42, 8'h43,
                                    8'h44, 8'h45, 8'h50, 8'h51, 8'h52, 8'h53};

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  cth_ui_top i_cth_ui_top (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .conv_in   (conv_in),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata),
    .reg_rdata (reg_rdata),
    .reg_rvld  (reg_rvld),
    .sense_cfg (sense_cfg),
    .tune_zero (tune_zero),
    .tune_one  (tune_one),
    .hall_out  (hall_out)
  );

  cth_host_model i_cth_host_model (
    .core_clk  (core_clk),
    .reg_rdata (reg_rdata),
    .reg_rvld  (reg_rvld),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata)
  );

  // xorshift source for stimulus
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  // compare register read data
  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // compare wide outputs: tuning results, hall differences, valid pulses
  task automatic chk_out(input string nm, input logic [34:0] e, input logic [34:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read one place and compare with the model
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    logic [7:0] e;
    logic       v;
    i_cth_host_model.rd(a, d, v);
    e = (a == 8'h11) ? fl : mreg[a];
    if (a == 8'h42)
      e[1] = (tix[0] >= 0) || (tix[1] >= 0);
    chk_out("read_valid", 35'(1), 35'(v));
    chk_reg($sformatf("reg_%h", a), e, d);
  endtask

  // write one place and track what the model expects to be stored
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cth_host_model.wr(a, d);
    if ((a >= 8'h50) && (a <= 8'h53))
      mreg[a] = (d == 8'h00) ? 8'h01 : d;
    else if (a == 8'h42)
      mreg[a] = d & 8'hfc;
    else if ((a >= 8'h40) && (a <= 8'h45))
      mreg[a] = d;
    if (a == 8'h42 && d[0])
      for (int k = 0; k < 2; k++)
      begin
        tix[k]  = 9;
        tcmp[k] = 10'h200;
        fl[k]   = 1'b0;
        fl[k+4] = 1'b0;
      end
  endtask

  // one conversion; model updates average, flags, tuning or hall data
  task automatic conv(input int ch, input int c);
    int         d;
    logic [7:0] t;
    @(negedge core_clk);
    conv_in = {1'b1, ch[2:0], c[15:0]};
    @(negedge core_clk);
    conv_in.vld = 1'b0;
    if (ch > 1)
    begin
      hc[ch] = c;
      if (ch == 5)
        chk_out("hall", {1'b1, 17'(hc[2] - hc[3]), 17'(hc[4] - hc[5])}, hall_out);
      else
        chk_out("hall_vld", 35'(0), 35'(hall_out.vld));
    end
    else if (tix[ch] >= 0)
    begin
      t = mreg[8'h43 + ch];
      if (c > int'(t[7:4]) * 256)
        tcmp[ch][tix[ch]] = 1'b0;
      if (tix[ch] > 0)
        tcmp[ch][tix[ch]-1] = 1'b1;
      tix[ch]--;
      if (tix[ch] < 0)
        sdd[ch] = 0;
    end
    else if (sdd[ch] == 0)
    begin
      long_term_average[ch] = c;
      sdd[ch] = 1;
    end
    else
    begin
      d       = (c > long_term_average[ch]) ? c - long_term_average[ch] : 0;
      fl[ch]  = d > mreg[8'h50 + 2 * ch];
      fl[ch+4] = d > ((mreg[8'h51 + 2 * ch] * long_term_average[ch]) >> 8);
      long_term_average[ch] = long_term_average[ch] + ((c - long_term_average[ch]) >>> 4);
    end
  endtask

  // tuning results of both channels against the model
  task automatic chk_tune();
    chk_out("tune_zero", 35'({mreg[8'h43][3:0], tcmp[0]}), 35'(tune_zero));
    chk_out("tune_one", 35'({mreg[8'h44][3:0], tcmp[1]}), 35'(tune_one));
  endtask

  // counts, verdict and end of run
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end

  // main sequence
  initial
  begin
    foreach (mreg[i])
      mreg[i] = 8'h00;
    mreg[8'h43] = 8'h88;
    mreg[8'h44] = 8'h88;
    mreg[8'h50] = 8'h10;
    mreg[8'h52] = 8'h10;
    mreg[8'h51] = 8'h20;
    mreg[8'h53] = 8'h20;
    tix = '{-1, -1};
    sdd = '{0, 0};
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    foreach (addrs[i])
      rd_chk(addrs[i]);
    $display("test reset_values done");
    foreach (addrs[i])
      wr(addrs[i], (addrs[i] == 8'h42) ? 8'(rnd() & 8'hfe) : 8'(rnd()));
    foreach (addrs[i])
      rd_chk(addrs[i]);
    chk_out("sense_cfg", 35'({mreg[8'h40], mreg[8'h41], mreg[8'h42], mreg[8'h45]}), 35'(sense_cfg));
    wr(8'h50, 8'h00);
    rd_chk(8'h50);
    $display("test register_access done");
    for (int i = 0; i < 80; i++)
    begin
      if (i % 6 == 0)
        wr(8'h50 + 8'(rnd() % 4), 8'(rnd() % 24));
      conv(i % 2 ? 1 : int'(rnd() % 2), 1000 + int'(rnd() % 160) - 40);
      rd_chk(8'h11);
    end
    $display("test flags done");
    for (int i = 0; i < 40; i++)
      conv((i % 9 == 8) ? 5 : 2 + int'(rnd() % 6), int'(rnd() % 65536));
    rd_chk(8'h11);
    $display("test hall done");
    wr(8'h42, 8'h01);
    repeat (3) @(negedge core_clk);
    rd_chk(8'h42);
    chk_tune();
    for (int i = 0; i < 10; i++)
    begin
      conv(0, int'(rnd() % 65536));
      conv(1, int'(rnd() % 65536));
      rd_chk(8'h11);
    end
    repeat (2) @(negedge core_clk);
    chk_tune();
    rd_chk(8'h42);
    conv(0, 2000);
    conv(0, 2100);
    rd_chk(8'h11);
    $display("test tuning done");
    complete_run();
  end
endmodule
